// file: hdl/diag_record_timestamp.sv
// diagnostic record of a two-channel analog input module, read byte-wise by the coupler.
// assumes error sources are synchronous to i_clock; reset is the power-on event.
//
// Operation
// - summary bits for module, internal, external, channel errors
// - module info: class 0101b, channel info bit
// - internal byte: buffer overflow, comm, lost interrupt
// - channel type 71h, analog input
// - eight diagnostic bits per channel
// - channel count is two
// - group error bits for channels 0 and 1
// - channel bytes: param, lost interrupt, under, over
// - timestamp holds ticker value at diagnostic
// - ticker starts from zero at power-on
// - ticker wraps after 2^32-1 us
// - canopen 2F01h full record, 2F00h first four
// - ethercat 5005h, summary 02h, timestamp 13h
// - incoming and going events, intermediate changes lost
`timescale 1ns/10ps
module diag_record_timestamp #(
   parameter int unsigned NUM_CHANNELS = 2
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // error sources, levels
   input wire logic i_module_fail,
   input wire logic i_external_error,
   input wire logic i_aux_supply_missing,
   input wire logic i_param_error,
   input wire logic i_diag_buffer_overflow,
   input wire logic i_internal_comm_error,
   input wire logic i_process_int_lost,
   input wire logic [NUM_CHANNELS-1:0] i_ch_param_error,
   input wire logic [NUM_CHANNELS-1:0] i_ch_int_lost,
   input wire logic [NUM_CHANNELS-1:0] i_ch_underflow,
   input wire logic [NUM_CHANNELS-1:0] i_ch_overflow,
   // record read port from the coupler
   input wire logic i_rd_req,
   input wire logic i_rd_ethercat,
   input wire logic [15:0] i_rd_index,
   input wire logic [7:0] i_rd_subindex,
   output logic o_rd_valid,
   output logic o_rd_error,
   output logic [7:0] o_rd_data,
   // diagnostic events
   output logic o_diag_incoming,
   output logic o_diag_going,
   output logic o_diag_active,
   output logic [31:0] o_ticks
);
   // the byte map below has exactly two channel slots
   if (NUM_CHANNELS != 2) begin : g_bad_channels
      $error("diag_record_timestamp: only two channels supported");
   end

   // event tracker: clear until a cause shows, raised until every cause is gone
   typedef enum logic {
      DIAG_CLEAR,
      DIAG_RAISED
   } diag_state_t;

   logic [31:0] ticks;
   logic [7:0] chan_err_d [NUM_CHANNELS];
   logic [7:0] chan_err_q [NUM_CHANNELS];
   logic [7:0] group_d;
   logic [7:0] summary_d;
   logic [7:0] internal_d;
   logic [7:0] summary_q;
   logic [7:0] internal_q;
   logic [7:0] group_q;
   logic [31:0] stamp_q;
   diag_state_t state_q;
   diag_state_t state_d;
   logic active;
   logic snap_take;
   logic snap_drop;
   logic cause;
   logic inc_q;
   logic going_q;
   logic [7:0] rd_data_q;
   logic rd_valid_q;
   logic rd_error_q;
   logic [4:0] ofs;
   logic ofs_ok;
   logic [7:0] byte_sel;

   us_ticker #(
      .DIVIDE(diag_record_pkg::TICK_CYCLES)
   ) u_ticker (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .o_ticks(ticks)
   );

   // live channel bytes, reserved bits held at zero
   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
      always_comb begin
         chan_err_d[c] = 8'h00;
         chan_err_d[c][diag_record_pkg::CH_PARAM] = i_ch_param_error[c];
         chan_err_d[c][diag_record_pkg::CH_PI_LOST] = i_ch_int_lost[c];
         chan_err_d[c][diag_record_pkg::CH_UNDER] = i_ch_underflow[c];
         chan_err_d[c][diag_record_pkg::CH_OVER] = i_ch_overflow[c];
      end
      assign group_d[c] = |chan_err_d[c];
   end
   assign group_d[7:NUM_CHANNELS] = '0;

   always_comb begin
      summary_d = 8'h00;
      summary_d[diag_record_pkg::SUM_MODULE_FAIL] = i_module_fail;
      summary_d[diag_record_pkg::SUM_INTERNAL] =
         i_diag_buffer_overflow | i_internal_comm_error | i_process_int_lost;
      summary_d[diag_record_pkg::SUM_EXTERNAL] = i_external_error;
      summary_d[diag_record_pkg::SUM_CHANNEL] = |group_d;
      summary_d[diag_record_pkg::SUM_AUX_SUPPLY] = i_aux_supply_missing;
      summary_d[diag_record_pkg::SUM_PARAM] = i_param_error;
      internal_d = 8'h00;
      internal_d[diag_record_pkg::INT_BUF_OVF] = i_diag_buffer_overflow;
      internal_d[diag_record_pkg::INT_COMM] = i_internal_comm_error;
      internal_d[diag_record_pkg::INT_PI_LOST] = i_process_int_lost;
   end

   assign cause = |summary_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         DIAG_CLEAR: begin
            if (cause) begin
               state_d = DIAG_RAISED;
            end
         end
         DIAG_RAISED: begin
            if (!cause) begin
               state_d = DIAG_CLEAR;
            end
         end
         default: begin
            state_d = DIAG_CLEAR;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_q <= DIAG_CLEAR;
      end else if (i_clk_en) begin
         state_q <= state_d;
      end
   end

   assign active = state_q == DIAG_RAISED;
   // record frozen from incoming to going, so changes inside the window are dropped
   assign snap_take = i_clk_en && cause && !active;
   assign snap_drop = i_clk_en && !cause && active;

   // one-cycle event pulses, both registered
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         inc_q <= 1'b0;
      end else if (i_clk_en) begin
         inc_q <= cause && !active;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         going_q <= 1'b0;
      end else if (i_clk_en) begin
         going_q <= !cause && active;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         summary_q <= 8'h00;
      end else if (snap_take) begin
         summary_q <= summary_d;
      end else if (snap_drop) begin
         summary_q <= 8'h00;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         internal_q <= 8'h00;
      end else if (snap_take) begin
         internal_q <= internal_d;
      end else if (snap_drop) begin
         internal_q <= 8'h00;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         group_q <= 8'h00;
      end else if (snap_take) begin
         group_q <= group_d;
      end else if (snap_drop) begin
         group_q <= 8'h00;
      end
   end

   // going record: errors cleared, timestamp marks the departure
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         stamp_q <= diag_record_pkg::TICKER_RESET;
      end else if (snap_take) begin
         stamp_q <= ticks;
      end else if (snap_drop) begin
         stamp_q <= ticks;
      end
   end

   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan_q
      always_ff @(posedge i_clock) begin
         if (i_sys_rst) begin
            chan_err_q[c] <= 8'h00;
         end else if (snap_take) begin
            chan_err_q[c] <= chan_err_d[c];
         end else if (snap_drop) begin
            chan_err_q[c] <= 8'h00;
         end
      end
   end

   // address decode for both coupler protocols
   always_comb begin
      ofs = 5'h00;
      ofs_ok = 1'b0;
      if (i_rd_ethercat) begin
         if (i_rd_index == diag_record_pkg::ETHERCAT_INDEX &&
             i_rd_subindex >= diag_record_pkg::ETHERCAT_SUB_FIRST &&
             i_rd_subindex <= diag_record_pkg::ETHERCAT_SUB_TIMESTAMP) begin
            ofs = 5'(i_rd_subindex - diag_record_pkg::ETHERCAT_SUB_FIRST);
            ofs_ok = 1'b1;
         end else if (i_rd_index == diag_record_pkg::ETHERCAT_INDEX &&
             i_rd_subindex > diag_record_pkg::ETHERCAT_SUB_TIMESTAMP &&
             i_rd_subindex <= diag_record_pkg::ETHERCAT_SUB_TIMESTAMP + 8'h03) begin
            // remaining timestamp bytes follow the 13h entry
            ofs = 5'(i_rd_subindex - diag_record_pkg::ETHERCAT_SUB_FIRST);
            ofs_ok = 1'b1;
         end
      end else begin
         if (i_rd_index == diag_record_pkg::CANOPEN_INDEX_RECORD &&
             i_rd_subindex <= {3'h0, diag_record_pkg::RECORD_LAST}) begin
            ofs = i_rd_subindex[4:0];
            ofs_ok = 1'b1;
         end else if (i_rd_index == diag_record_pkg::CANOPEN_INDEX_HEAD &&
             i_rd_subindex < {3'h0, diag_record_pkg::CANOPEN_HEAD_BYTES}) begin
            ofs = i_rd_subindex[4:0];
            ofs_ok = 1'b1;
         end
      end
   end

   always_comb begin
      case (ofs)
         diag_record_pkg::OFS_SUMMARY: byte_sel = summary_q;
         diag_record_pkg::OFS_MODULE_INFO: begin
            byte_sel = {3'h0, 1'b1, diag_record_pkg::MODULE_CLASS_ANALOG};
         end
         diag_record_pkg::OFS_RSVD_BYTE: byte_sel = 8'h00;
         diag_record_pkg::OFS_INTERNAL: byte_sel = internal_q;
         diag_record_pkg::OFS_CHANNEL_TYPE: begin
            byte_sel = {1'b0, diag_record_pkg::CHTYPE_ANA_IN};
         end
         diag_record_pkg::OFS_BITS_PER_CH: byte_sel = diag_record_pkg::BITS_PER_CHANNEL;
         diag_record_pkg::OFS_CHANNEL_COUNT: byte_sel = diag_record_pkg::CHANNEL_COUNT;
         diag_record_pkg::OFS_GROUP_ERROR: byte_sel = group_q;
         diag_record_pkg::OFS_CHAN0_ERROR: byte_sel = chan_err_q[0];
         diag_record_pkg::OFS_CHAN1_ERROR: byte_sel = chan_err_q[1];
         diag_record_pkg::OFS_TIMESTAMP: byte_sel = stamp_q[7:0];
         diag_record_pkg::OFS_TIMESTAMP + 5'h01: byte_sel = stamp_q[15:8];
         diag_record_pkg::OFS_TIMESTAMP + 5'h02: byte_sel = stamp_q[23:16];
         diag_record_pkg::OFS_TIMESTAMP + 5'h03: byte_sel = stamp_q[31:24];
         default: byte_sel = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rd_valid_q <= 1'b0;
         rd_error_q <= 1'b0;
      end else if (i_clk_en) begin
         rd_valid_q <= i_rd_req && ofs_ok;
         rd_error_q <= i_rd_req && !ofs_ok;
      end
   end

   // data holds the last answer until the next request
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rd_data_q <= 8'h00;
      end else if (i_clk_en && i_rd_req) begin
         rd_data_q <= ofs_ok ? byte_sel : 8'h00;
      end
   end

   assign o_rd_valid = rd_valid_q;
   assign o_rd_error = rd_error_q;
   assign o_rd_data = rd_data_q;
   assign o_diag_incoming = inc_q;
   assign o_diag_going = going_q;
   assign o_diag_active = active;
   assign o_ticks = ticks;
endmodule // diag_record_timestamp

// file: pkg/diag_record_pkg.sv
// diagnostic record package: record layout, constant bytes, bit positions, timing.
// assumes a 10 MHz system clock and a byte-wide record read port.
package diag_record_pkg;
   localparam int unsigned CLOCK_HZ = 10_000_000;
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1_000_000) * TICK_US;

   // record byte offsets, taken as ethercat subindex minus 02h
   localparam logic [4:0] OFS_SUMMARY = 5'h00;
   localparam logic [4:0] OFS_MODULE_INFO = 5'h01;
   localparam logic [4:0] OFS_RSVD_BYTE = 5'h02;
   localparam logic [4:0] OFS_INTERNAL = 5'h03;
   localparam logic [4:0] OFS_CHANNEL_TYPE = 5'h04;
   localparam logic [4:0] OFS_BITS_PER_CH = 5'h05;
   localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
   localparam logic [4:0] OFS_GROUP_ERROR = 5'h07;
   localparam logic [4:0] OFS_CHAN0_ERROR = 5'h08;
   localparam logic [4:0] OFS_CHAN1_ERROR = 5'h09;
   localparam logic [4:0] OFS_TIMESTAMP = 5'h11;
   localparam logic [4:0] RECORD_LAST = 5'h14;

   // bus coupler object indices
   localparam logic [15:0] CANOPEN_INDEX_RECORD = 16'h2f01;
   localparam logic [15:0] CANOPEN_INDEX_HEAD = 16'h2f00;
   localparam logic [4:0] CANOPEN_HEAD_BYTES = 5'h04;
   localparam logic [15:0] ETHERCAT_INDEX = 16'h5005;
   localparam logic [7:0] ETHERCAT_SUB_FIRST = 8'h02;
   localparam logic [7:0] ETHERCAT_SUB_SUMMARY = 8'h02;
   localparam logic [7:0] ETHERCAT_SUB_TIMESTAMP = 8'h13;

   // summary bits
   localparam int SUM_MODULE_FAIL = 0;
   localparam int SUM_INTERNAL = 1;
   localparam int SUM_EXTERNAL = 2;
   localparam int SUM_CHANNEL = 3;
   localparam int SUM_AUX_SUPPLY = 4;
   localparam int SUM_PARAM = 7;
   // internal byte bits
   localparam int INT_BUF_OVF = 3;
   localparam int INT_COMM = 4;
   localparam int INT_PI_LOST = 6;
   // channel error bits
   localparam int CH_PARAM = 0;
   localparam int CH_PI_LOST = 5;
   localparam int CH_UNDER = 6;
   localparam int CH_OVER = 7;

   localparam logic [3:0] MODULE_CLASS_ANALOG = 4'h5;
   localparam int MODINFO_CH_PRESENT = 4;
   localparam logic [6:0] CHTYPE_DIG_IN = 7'h70;
   localparam logic [6:0] CHTYPE_ANA_IN = 7'h71;
   localparam logic [6:0] CHTYPE_DIG_OUT = 7'h72;
   localparam logic [6:0] CHTYPE_ANA_OUT = 7'h73;
   localparam logic [6:0] CHTYPE_ANA_INOUT = 7'h74;
   localparam logic [6:0] CHTYPE_COUNTER = 7'h76;
   localparam logic [7:0] BITS_PER_CHANNEL = 8'h08;
   localparam logic [7:0] CHANNEL_COUNT = 8'h02;
   localparam logic [31:0] TICKER_RESET = 32'h0000_0000;
endpackage

// file: hdl/us_ticker.sv
// free-running microsecond ticker.
// assumes i_clock at the package clock rate; reset stands for power-on.
`timescale 1ns/10ps
module us_ticker #(
   parameter int unsigned DIVIDE = diag_record_pkg::TICK_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   output logic [31:0] o_ticks
);
   // prescaler is eight bits wide
   if (DIVIDE < 1 || DIVIDE > 255) begin : g_bad_divide
      $error("us_ticker: DIVIDE out of range");
   end

   logic [7:0] pre_q;
   logic [31:0] ticks_q;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         pre_q <= 8'h00;
      end else if (i_clk_en) begin
         if (pre_q == 8'(DIVIDE - 1)) begin
            pre_q <= 8'h00;
         end else begin
            pre_q <= pre_q + 8'h01;
         end
      end
   end

   // 32-bit add wraps to zero naturally after all ones
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ticks_q <= diag_record_pkg::TICKER_RESET;
      end else if (i_clk_en && pre_q == 8'(DIVIDE - 1)) begin
         ticks_q <= ticks_q + 32'h0000_0001;
      end
   end

   assign o_ticks = ticks_q;
endmodule // us_ticker

// file: verification/diag_record_timestamp_properties.sv
// checker for the diagnostic record block: read answers, events, ticker.
// assumes binding onto the top module; one clock domain.
`timescale 1ns/10ps
module diag_record_timestamp_properties (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_rd_req,
   input wire logic i_rd_ethercat,
   input wire logic [15:0] i_rd_index,
   input wire logic [7:0] i_rd_subindex,
   input wire logic o_rd_valid,
   input wire logic o_rd_error,
   input wire logic [7:0] o_rd_data,
   input wire logic o_diag_incoming,
   input wire logic o_diag_going,
   input wire logic o_diag_active,
   input wire logic [31:0] o_ticks
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   a_read_answered: assert property (i_clk_en && i_rd_req |=> o_rd_valid ^ o_rd_error)
      else $error("read request not answered");
   a_no_idle_answer: assert property (i_clk_en && !i_rd_req |=> !o_rd_valid && !o_rd_error)
      else $error("answer without request");
   a_error_data_zero: assert property (o_rd_error |-> o_rd_data == 8'h00)
      else $error("refused read returned data");
   a_type_byte: assert property (i_clk_en && i_rd_req && !i_rd_ethercat
      && i_rd_index == 16'h2f01 && i_rd_subindex == 8'h04 |=> o_rd_valid && o_rd_data == 8'h71)
      else $error("channel type byte wrong");
   a_incoming_edge: assert property (o_diag_incoming |-> !$past(o_diag_active))
      else $error("incoming while already active");
   a_going_edge: assert property (o_diag_going |-> $past(o_diag_active) && !o_diag_incoming)
      else $error("going without active diagnostic");
   a_ticker_step: assert property ($changed(o_ticks) |-> o_ticks == $past(o_ticks) + 32'h1)
      else $error("ticker step not one");
   a_ticker_rate: assert property ($changed(o_ticks) |=> $stable(o_ticks) [*8])
      else $error("ticker runs too fast");
   a_ticks_from_zero: assert property ($fell(i_sys_rst) |-> o_ticks == 32'h0)
      else $error("ticker not zero after reset");
endmodule // diag_record_timestamp_properties

bind diag_record_timestamp diag_record_timestamp_properties chk (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_rd_req(i_rd_req),
   .i_rd_ethercat(i_rd_ethercat), .i_rd_index(i_rd_index), .i_rd_subindex(i_rd_subindex),
   .o_rd_valid(o_rd_valid), .o_rd_error(o_rd_error), .o_rd_data(o_rd_data),
   .o_diag_incoming(o_diag_incoming), .o_diag_going(o_diag_going),
   .o_diag_active(o_diag_active), .o_ticks(o_ticks));

// file: verification/coupler_model.sv
// bus coupler model: issues record reads and takes the answer.
// assumes requests launched at the falling edge, answer one cycle later.
`timescale 1ns/10ps
module coupler_model (
   input wire logic i_clock,
   input wire logic i_rd_valid,
   input wire logic i_rd_error,
   input wire logic [7:0] i_rd_data,
   output logic o_rd_req,
   output logic o_rd_ethercat,
   output logic [15:0] o_rd_index,
   output logic [7:0] o_rd_subindex
);
   initial begin
      o_rd_req = 1'b0;
      o_rd_ethercat = 1'b0;
      o_rd_index = 16'h0;
      o_rd_subindex = 8'h0;
   end
   task automatic read(input logic eth, input logic [15:0] idx, input logic [7:0] sub,
         output logic [7:0] data, output logic ok, output logic err);
      @(negedge i_clock);
      o_rd_req = 1'b1;
      o_rd_ethercat = eth;
      o_rd_index = idx;
      o_rd_subindex = sub;
      @(negedge i_clock);
      ok = i_rd_valid;
      err = i_rd_error;
      data = i_rd_data;
      o_rd_req = 1'b0;
      // idle address never repeats the last one
      o_rd_index = ~idx;
      o_rd_subindex = ~sub;
   endtask
endmodule // coupler_model

// file: verification/diag_record_timestamp_tb_top.sv
// testbench: record defaults, addressing, diagnostic events and timestamps.
// assumes the bound checker and the coupler model beside the block.
`timescale 1ns/10ps
module diag_record_timestamp_tb_top;
   logic i_clock, i_sys_rst, rd_req, rd_eth, rd_valid, rd_error, incoming, going, active, clk_en;
   logic [14:0] src;
   logic [15:0] rd_index;
   logic [7:0] rd_sub, rd_data;
   logic [31:0] ticks;
   int mismatches, check_count;
   diag_record_timestamp uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
      .i_module_fail(src[0]), .i_external_error(src[1]), .i_aux_supply_missing(src[2]),
      .i_param_error(src[3]), .i_diag_buffer_overflow(src[4]), .i_internal_comm_error(src[5]),
      .i_process_int_lost(src[6]), .i_ch_param_error(src[8:7]), .i_ch_int_lost(src[10:9]),
      .i_ch_underflow(src[12:11]), .i_ch_overflow(src[14:13]), .i_rd_req(rd_req),
      .i_rd_ethercat(rd_eth), .i_rd_index(rd_index), .i_rd_subindex(rd_sub),
      .o_rd_valid(rd_valid), .o_rd_error(rd_error), .o_rd_data(rd_data),
      .o_diag_incoming(incoming), .o_diag_going(going), .o_diag_active(active), .o_ticks(ticks));
   coupler_model coupler (.i_clock(i_clock), .i_rd_valid(rd_valid), .i_rd_error(rd_error),
      .i_rd_data(rd_data), .o_rd_req(rd_req), .o_rd_ethercat(rd_eth), .o_rd_index(rd_index),
      .o_rd_subindex(rd_sub));
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic eth, input logic [15:0] idx, input logic [7:0] sub,
         input logic hit, input logic [7:0] exp);
      logic [7:0] d;
      logic ok, er;
      coupler.read(eth, idx, sub, d, ok, er);
      check("rd_valid", ok, hit);
      check("rd_error", er, !hit);
      check("rd_data", d, hit ? exp : 8'h00);
   endtask
   // packed {chan1, chan0, group, internal, summary}
   function automatic logic [39:0] exp_bytes(input logic [14:0] s);
      logic [7:0] c0, c1, in, g;
      c0 = {s[13], s[11], s[9], 4'h0, s[7]};
      c1 = {s[14], s[12], s[10], 4'h0, s[8]};
      in = {1'b0, s[6], 1'b0, s[5], s[4], 3'h0};
      g = {6'h0, |c1, |c0};
      return {c1, c0, g, in, s[3], 2'h0, s[2], |g, s[1], |in, s[0]};
   endfunction
   task automatic t_defaults();
      logic [7:0] x;
      for (int o = 0; o < 21; o++) begin
         x = o == 1 ? 8'h15 : o == 4 ? 8'h71 : o == 5 ? 8'h08 : o == 6 ? 8'h02 : 8'h00;
         rd(1'b0, 16'h2f01, 8'(o), 1'b1, x);
      end
   endtask
   task automatic t_ticker();
      logic [31:0] t;
      int n;
      t = ticks;
      n = 0;
      while (ticks === t && n < 12) begin
         @(negedge i_clock);
         n++;
      end
      check("tick_wait", n < 12, 1'b1);
      if (n >= 12) end_of_test();
      repeat (10) @(negedge i_clock);
      check("ticks", ticks, t + 32'h2);
   endtask
   // clock enable low must hold the ticker still
   task automatic t_freeze();
      logic [31:0] t;
      @(negedge i_clock);
      clk_en = 1'b0;
      t = ticks;
      repeat (15) @(negedge i_clock);
      check("ticks_frozen", ticks, t);
      clk_en = 1'b1;
   endtask
   task automatic t_addressing();
      rd(1'b0, 16'h2f00, 8'h01, 1'b1, 8'h15);
      rd(1'b0, 16'h2f00, 8'h04, 1'b0, 8'h00);
      rd(1'b0, 16'h2f01, 8'h15, 1'b0, 8'h00);
      rd(1'b1, 16'h5005, 8'h06, 1'b1, 8'h71);
      rd(1'b1, 16'h5005, 8'h01, 1'b0, 8'h00);
      rd(1'b1, 16'h5005, 8'h17, 1'b0, 8'h00);
      rd(1'b1, 16'h5000, 8'h02, 1'b0, 8'h00);
   endtask
   task automatic t_event(input logic [14:0] s);
      logic [39:0] e;
      logic [31:0] t0;
      logic [31:0] t1;
      e = exp_bytes(s);
      @(negedge i_clock);
      t0 = ticks;
      src = s;
      @(negedge i_clock);
      check("incoming", incoming, 1'b1);
      check("active", active, 1'b1);
      // other causes while active must not reach the record; one cause kept so it stays raised
      src = ~s | 15'h0001;
      for (int k = 0; k < 5; k++)
         rd(1'b0, 16'h2f01, 8'(k < 2 ? 3 * k : k + 5), 1'b1, e[8*k+:8]);
      for (int k = 0; k < 4; k++)
         rd(1'b1, 16'h5005, 8'(8'h13 + k), 1'b1, t0[8*k+:8]);
      @(negedge i_clock);
      t1 = ticks;
      src = 15'h0;
      @(negedge i_clock);
      check("going", going, 1'b1);
      check("active_clear", active, 1'b0);
      rd(1'b1, 16'h5005, 8'h02, 1'b1, 8'h00);
      rd(1'b1, 16'h5005, 8'h13, 1'b1, t1[7:0]);
   endtask
   initial begin
      src = 15'h0;
      clk_en = 1'b1;
      i_sys_rst = 1'b1;
      repeat (2) @(negedge i_clock);
      i_sys_rst = 1'b0;
      check("ticks_reset", ticks, 32'h0);
      t_defaults();
      t_ticker();
      t_freeze();
      t_addressing();
      for (int i = 0; i < 15; i++)
         t_event(15'h1 << i);
      t_event(15'h7fff);
      end_of_test();
   end
endmodule // diag_record_timestamp_tb_top
